/* hw/tx_enable_decode.sv */
// Decodes the controller state into the analog block enable lines.
`timescale 1ns/1ns
module tx_enable_decode
(
   input  wire tx_power_pkg::pwr_state_e state_in,
   input  wire logic                     path_sel_in,
   output logic                          ch1_enable_line_out,
   output logic                          ch2_enable_line_out,
   output logic                          doubler_phase_enable_line_out,
   output logic                          lo_detector_input_enable_out,
   output logic                          lo_detector_path_select_out,
   output logic                          lo_detector_output_enable_out
);
   import tx_power_pkg::*;
   logic on_w;
   always_comb
   begin
      on_w                          = (state_in == on_state);
      ch1_enable_line_out           = on_w;
      ch2_enable_line_out           = on_w;
      doubler_phase_enable_line_out = on_w;
      lo_detector_input_enable_out  = on_w;
      lo_detector_output_enable_out = on_w;
      lo_detector_path_select_out   = on_w & path_sel_in;
   end
endmodule

/* hw/tx_power_defines.svh */
// Register offsets, field positions, command codes and reset values of the TX power controller.
`ifndef TX_POWER_DEFINES_SVH
`define TX_POWER_DEFINES_SVH
`define ADDR_W            7
`define DATA_W            8
`define OFS_OFF_CMD       7'h01
`define OFS_ON_CMD        7'h02
`define OFS_TEST          7'h09
`define CMD_STATE_CODE    8'h04
`define TEST_RESET        8'h00
`define TEST_TMP_BIT      2
`define TEST_WR_MASK      8'h04
`endif

/* hw/tx_power_pkg.sv */
// Types shared by the TX power controller files.
package tx_power_pkg;
   typedef enum logic {off_state, on_state} pwr_state_e;
   typedef logic [7:0] byte_t;
endpackage

/* hw/tx_power_state_control.sv */
// Two-state enable controller with the temperature sensor test register.
// Summary of operation
// - Test register bit 2 activates the temperature sensor; resets to zero.
// - Exactly two states, off and on, switching the key analog blocks together.
// - Off state disables and on state enables every state-driven block; the detector input stays off while test bit 2 is set.
// - Writing 0x04 to register 0x02 enters on state, enabling both channels.
// - Writing 0x04 to register 0x01 enters off state, dropping every enable output except the temperature sensor enable.
// - On state enables the doubler and its buffer; off disables them.
// - The doubler line also enables both phase selections in on state.
// - On state enables the transmit input of the oscillator peak detector while test bit 2 is clear.
// - On state selects detector input or output; off disables detector output.
// - Temperature sensor and peak detector input are never active together; the detector output enable still follows on state.
`timescale 1ns/1ns
`include "tx_power_defines.svh"
module tx_power_state_control
(
   input  wire logic                clk_sys_in,
   input  wire logic                resetn_in,
   input  wire logic                reg_wr_in,
   input  wire logic                reg_rd_in,
   input  wire logic [6:0]          reg_addr_in,
   input  wire tx_power_pkg::byte_t reg_wdata_in,
   input  wire logic                path_sel_in,
   output tx_power_pkg::byte_t      reg_rdata_out,
   output logic                     reg_hit_out,
   output logic                     ch1_enable_line_out,
   output logic                     ch2_enable_line_out,
   output logic                     doubler_phase_enable_line_out,
   output logic                     lo_detector_input_enable_out,
   output logic                     lo_detector_path_select_out,
   output logic                     lo_detector_output_enable_out,
   output logic                     temp_sensor_enable_out,
   output logic                     on_state_out
);
   import tx_power_pkg::*;

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed
   {
      pwr_state_e state;
      byte_t      test;
      byte_t      rdata;
      logic       hit;
   } ctrl_s;

   ctrl_s s_q;
   ctrl_s s_d;

   function automatic logic is_cmd(input logic [6:0] a, input logic [6:0] o,
                                   input byte_t d);
      is_cmd = (a == o) && (d == `CMD_STATE_CODE);
   endfunction

   always_comb
   begin
      s_d     = s_q;
      s_d.hit = 1'b0;
      if (reg_wr_in)
      begin
         // Only the command code changes state; other values are ignored.
         if (is_cmd(reg_addr_in, `OFS_ON_CMD, reg_wdata_in))
            s_d.state = on_state;
         else if (is_cmd(reg_addr_in, `OFS_OFF_CMD, reg_wdata_in))
            s_d.state = off_state;
         if (reg_addr_in == `OFS_TEST)
            s_d.test = reg_wdata_in & `TEST_WR_MASK;
      end
      if (reg_rd_in)
      begin
         s_d.hit   = (reg_addr_in == `OFS_TEST);
         s_d.rdata = (reg_addr_in == `OFS_TEST) ? s_q.test : `TEST_RESET;
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         s_q.state <= off_state;
         s_q.test  <= `TEST_RESET;
         s_q.rdata <= `TEST_RESET;
         s_q.hit   <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   logic det_in_w;
   tx_enable_decode u_decode
   (
      .state_in                      (s_q.state),
      .path_sel_in                   (path_sel_in),
      .ch1_enable_line_out           (ch1_enable_line_out),
      .ch2_enable_line_out           (ch2_enable_line_out),
      .doubler_phase_enable_line_out (doubler_phase_enable_line_out),
      .lo_detector_input_enable_out  (det_in_w),
      .lo_detector_path_select_out   (lo_detector_path_select_out),
      .lo_detector_output_enable_out (lo_detector_output_enable_out)
   );

   // The detector input yields to the temperature sensor so both never run at once.
   assign temp_sensor_enable_out       = s_q.test[`TEST_TMP_BIT];
   assign lo_detector_input_enable_out = det_in_w & ~s_q.test[`TEST_TMP_BIT];
   assign on_state_out                 = (s_q.state == on_state);
   assign reg_rdata_out                = s_q.rdata;
   assign reg_hit_out                  = s_q.hit;
endmodule

/* sim/mcu_host.sv */
// Host model issuing single-byte register strobes.
`timescale 1ns/1ns
module mcu_host
(
   input  wire logic  clk_in,
   output logic       wr_out,
   output logic       rd_out,
   output logic [6:0] addr_out,
   output logic [7:0] data_out
);
   initial {wr_out, rd_out, addr_out, data_out} = '0;
   // Released address and data lines show inverted values so stale data never looks valid.
   task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
      @(negedge clk_in);
      {wr_out, rd_out, addr_out, data_out} <= {w, !w, a, d};
      @(negedge clk_in);
      {wr_out, rd_out, addr_out, data_out} <= {2'b00, ~a, ~d};
   endtask
endmodule

/* sim/tb.sv */
// Self-checking bench for the TX power controller.
`timescale 1ns/1ns
module tb;
   import tx_power_pkg::*;
   logic clk_sys_in = 0, resetn_in = 0, wr, rd, ps = 0, st = 0, tt = 0, hit;
   logic [6:0] addr;
   byte_t wd, rdat;
   wire logic [7:0] o;
   int n_fail = 0, cmp_count = 0;
   initial forever #50 clk_sys_in = ~clk_sys_in;
   mcu_host h (.clk_in(clk_sys_in), .wr_out(wr), .rd_out(rd), .addr_out(addr), .data_out(wd));
   tx_power_state_control u_tx_power_state_control (.clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
      .reg_wdata_in(wd), .path_sel_in(ps), .reg_rdata_out(rdat), .reg_hit_out(hit),
      .ch1_enable_line_out(o[7]), .ch2_enable_line_out(o[6]),
      .doubler_phase_enable_line_out(o[5]), .lo_detector_input_enable_out(o[4]),
      .lo_detector_path_select_out(o[3]), .lo_detector_output_enable_out(o[2]),
      .temp_sensor_enable_out(o[1]), .on_state_out(o[0]));
   function automatic logic [7:0] exp_o(logic s, logic t, logic p);
      return {s, s, s, s & ~t, s & p, s, t, s};
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic op(input logic w, input logic [6:0] a, input byte_t d);
      h.xfer(w, a, d);
      if (w && d == 8'h04 && a inside {7'h01, 7'h02}) st = (a == 7'h02);
      if (w && a == 7'h09) tt = d[2];
      chk(o, exp_o(st, tt, ps));
      if (!w) chk({hit, rdat}, (a == 7'h09) ? {1'b1, 5'h00, tt, 2'b00} : 9'h000);
   endtask
   task automatic end_sim;
      $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      void'($urandom(55));
      repeat (6) @(posedge clk_sys_in);
      @(negedge clk_sys_in) resetn_in = 1;
      chk(o, 8'h00);
      op(0, 7'h09, 8'h00);
      op(1, 7'h02, 8'h04); op(1, 7'h02, 8'h05); op(1, 7'h01, 8'h04); op(1, 7'h01, 8'h84);
      op(1, 7'h09, 8'hFF); op(1, 7'h02, 8'h04); op(0, 7'h09, 8'h00); op(0, 7'h33, 8'h00);
      ps = 1; op(1, 7'h09, 8'hFB); op(0, 7'h02, 8'h00); op(1, 7'h01, 8'h04);
      $display("directed test done");
      repeat (200)
      begin
         ps = 1'($urandom);
         op(1'($urandom), 7'($urandom_range(0, 12)), $urandom_range(0, 1) ? 8'h04 : 8'($urandom));
      end
      $display("random test done");
      end_sim;
   end
   initial
   begin
      #1000000 n_fail++;
      end_sim;
   end
endmodule

/* sim/tx_power_props.sv */
// Concurrent checks on the ports of the TX power controller.
`timescale 1ns/1ns
module tx_power_props
(
   input wire logic                clk_sys_in, resetn_in, reg_wr_in, reg_rd_in, path_sel_in,
   input wire logic [6:0]          reg_addr_in,
   input wire tx_power_pkg::byte_t reg_wdata_in,
   input wire logic                reg_hit_out, ch1_enable_line_out, ch2_enable_line_out,
   input wire logic                doubler_phase_enable_line_out, lo_detector_input_enable_out,
   input wire logic                lo_detector_path_select_out, lo_detector_output_enable_out,
   input wire logic                temp_sensor_enable_out, on_state_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   logic cmd;
   assign cmd = reg_wr_in && reg_wdata_in == 8'h04;
   a_on: assert property (cmd && reg_addr_in == 7'h02 |=> on_state_out) else $error("no on");
   a_off: assert property (cmd && reg_addr_in == 7'h01 |=> !on_state_out && !ch1_enable_line_out)
      else $error("no off");
   a_hold: assert property (!(cmd && reg_addr_in inside {7'h01, 7'h02}) |=> $stable(on_state_out))
      else $error("state moved");
   a_grp: assert property (ch1_enable_line_out == on_state_out && ch2_enable_line_out == on_state_out
      && lo_detector_output_enable_out == on_state_out) else $error("group");
   a_dbl: assert property (doubler_phase_enable_line_out == on_state_out) else $error("dbl");
   a_det: assert property (lo_detector_input_enable_out == (on_state_out && !temp_sensor_enable_out))
      else $error("det in");
   a_sel: assert property (lo_detector_path_select_out == (on_state_out && path_sel_in))
      else $error("path");
   a_tmp: assert property (reg_wr_in && reg_addr_in == 7'h09 |=>
      temp_sensor_enable_out == $past(reg_wdata_in[2])) else $error("tmp");
   a_hit: assert property (reg_rd_in |=> reg_hit_out == ($past(reg_addr_in) == 7'h09))
      else $error("hit");
endmodule
bind tx_power_state_control tx_power_props u_props (.*);
